// file: logic/scd_spi.sv
// serial clock rate generator, data port and serial shifter with apb registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module scd_spi #(
    parameter int ADDR_W     = 12,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // serial clock pin
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe_n,
    // master-out data pin
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe_n,
    // master-in data pin
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe_n,
    // slave select input
    input  wire logic              slave_select_n
);
    import scd_pkg::*;

    if (ADDR_W < MIN_ADDR_W || ADDR_W > 12) begin : g_bad_addr
        $error("scd_spi address width must be 10 to 12");
    end

    logic [7:0]  sck_divider_value;
    logic [7:0]  tx_buf;
    logic [7:0]  sh;
    logic [7:0]  rx_head;
    logic [7:0]  rx_byte;
    logic        en;
    logic        mst;
    logic        clock_polarity_sel;
    logic        clock_phase_sel;
    logic        tx_buffer_empty;
    logic        write_collision_flag;
    logic        done_flag;
    logic        overrun_flag;
    scd_state_e  state;
    logic [7:0]  hc;
    logic        phase;
    logic [4:0]  edge_cnt;
    logic [2:0]  bit_cnt;
    logic        sck_prev;
    logic        ss_prev;
    logic [3:0]  slh_cnt;
    logic        slh_run;
    logic [11:0] addr;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_div;
    logic        hit_data;
    logic        mapped;
    logic        data_wr;
    logic        ms_start;
    logic        sl_load;
    logic        ss_fall;
    logic        s_act;
    logic        m_edge;
    logic        s_edge;
    logic        lead;
    logic        samp;
    logic        shft;
    logic        ser_in;
    logic        last;
    logic        slh_fire;
    logic        rx_ready;
    logic        rx_valid;
    logic        rd_pop;
    logic        busy;
    logic [31:0] next_rdata;

    // bus decode; the answer comes one cycle into the access phase
    assign addr       = 12'(paddr);
    assign acc        = psel & penable & ~pready;
    assign wr         = psel & penable & pready & pwrite;
    assign rd         = psel & penable & pready & ~pwrite;
    assign hit_ctrl   = scd_hit(addr, IDX_CTRL);
    assign hit_status = scd_hit(addr, IDX_STATUS);
    assign hit_div    = scd_hit(addr, IDX_DIV);
    assign hit_data   = scd_hit(addr, IDX_DATA);
    assign mapped     = hit_ctrl | hit_status | hit_div | hit_data;
    assign data_wr    = wr & hit_data;
    assign busy       = (state != SCD_IDLE);

    // serial event decode shared by both roles
    assign s_act    = en & ~mst & ~slave_select_n;
    assign ss_fall  = ss_prev & ~slave_select_n & en & ~mst;
    assign m_edge   = (state == SCD_RUN) && (hc == sck_divider_value); // R01
    assign s_edge   = s_act & (sck_in != sck_prev);
    assign lead     = m_edge ? ~phase : (sck_in != clock_polarity_sel);
    assign samp     = (m_edge | s_edge) & (lead ^ clock_phase_sel);
    assign shft     = (m_edge | s_edge) & ~(lead ^ clock_phase_sel);
    assign ser_in   = mst ? miso_in : mosi_in;
    assign last     = samp && (bit_cnt == LAST_BIT);
    assign rx_byte  = {sh[6:0], ser_in};
    assign rd_pop   = rd & hit_data & rx_valid;
    // a full receive fifo holds off the next master transfer
    assign ms_start = (state == SCD_IDLE) & en & mst & ~tx_buffer_empty & rx_ready; // R03
    assign sl_load  = ~tx_buffer_empty & ((ss_fall & ~busy) | (last & ~mst));
    assign slh_fire = slh_run && (slh_cnt == SLH_FIRE);

    always_comb begin
        next_rdata = '0;
        if (hit_ctrl) begin
            next_rdata[CTRL_EN]   = en;
            next_rdata[CTRL_MST]  = mst;
            next_rdata[CTRL_CPOL] = clock_polarity_sel;
            next_rdata[CTRL_CPHA] = clock_phase_sel;
        end else if (hit_status) begin
            next_rdata[ST_TXE]  = tx_buffer_empty;
            next_rdata[ST_WRITE_COLLISION_FLAG] = write_collision_flag;
            next_rdata[ST_DONE] = done_flag;
            next_rdata[ST_RXV]  = rx_valid;
            next_rdata[ST_OVR]  = overrun_flag;
            next_rdata[ST_BUSY] = busy;
        end else if (hit_div) begin
            next_rdata[7:0] = sck_divider_value;
        end else if (hit_data) begin
            next_rdata[7:0] = rx_head; // R04
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            if (acc) begin
                prdata <= next_rdata;
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en                 <= 1'b0;
            mst                <= 1'b0;
            clock_polarity_sel <= 1'b0;
            clock_phase_sel    <= 1'b0;
            sck_divider_value  <= DIV_RESET;
        end else begin
            if (wr && hit_ctrl) begin
                en                 <= pwdata[CTRL_EN];
                mst                <= pwdata[CTRL_MST];
                clock_polarity_sel <= pwdata[CTRL_CPOL];
                clock_phase_sel    <= pwdata[CTRL_CPHA];
            end
            if (wr && hit_div) begin
                sck_divider_value <= pwdata[7:0]; // R02
            end
        end
    end

    // transmit buffer; a write while occupied is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf          <= DATA_RESET;
            tx_buffer_empty <= 1'b1;
        end else if (data_wr && tx_buffer_empty) begin
            tx_buf          <= pwdata[7:0]; // R03
            tx_buffer_empty <= 1'b0;
        end else if (ms_start || sl_load) begin
            tx_buffer_empty <= 1'b1;
        end
    end

    // sticky flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag <= 1'b0;
            done_flag            <= 1'b0;
            overrun_flag         <= 1'b0;
        end else begin
            write_collision_flag <= (data_wr & ~tx_buffer_empty) // R13
                | (write_collision_flag & ~(wr & hit_status & pwdata[ST_WRITE_COLLISION_FLAG]));
            done_flag    <= (state == SCD_FIN) | (last & ~mst)
                | (done_flag & ~(wr & hit_status & pwdata[ST_DONE]));
            overrun_flag <= (last & ~rx_ready)
                | (overrun_flag & ~(wr & hit_status & pwdata[ST_OVR]));
        end
    end

    // master sequencer: sixteen half periods of divider plus one cycles each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= SCD_IDLE;
            hc       <= '0;
            phase    <= 1'b0;
            edge_cnt <= '0;
        end else begin
            case (state)
                SCD_IDLE: begin
                    hc       <= '0;
                    phase    <= 1'b0;
                    edge_cnt <= '0;
                    if (ms_start) begin
                        state <= SCD_RUN;
                    end
                end
                SCD_RUN: begin
                    if (!en || !mst) begin
                        state <= SCD_IDLE;
                    end else if (m_edge) begin
                        hc       <= '0; // R01
                        phase    <= ~phase;
                        edge_cnt <= edge_cnt + 1'b1;
                        if (edge_cnt == LAST_EDGE) begin
                            state <= SCD_FIN; // R14
                        end
                    end else begin
                        hc <= hc + 1'b1;
                    end
                end
                SCD_FIN: begin
                    state <= SCD_IDLE;
                end
                default: begin
                    state <= SCD_IDLE;
                end
            endcase
        end
    end

    // shift register and bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh      <= DATA_RESET;
            bit_cnt <= '0;
        end else begin
            if (ms_start || sl_load) begin
                sh <= tx_buf;
            end else if (samp) begin
                sh <= rx_byte;
            end
            if ((mst && !busy) || (!mst && !s_act)) begin
                bit_cnt <= '0;
            end else if (samp) begin
                bit_cnt <= bit_cnt + 1'b1; // R14
            end
        end
    end

    // slave pin history and the delayed change after the last edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev <= 1'b0;
            ss_prev  <= 1'b1;
            slh_cnt  <= '0;
            slh_run  <= 1'b0;
        end else begin
            sck_prev <= sck_in;
            ss_prev  <= slave_select_n;
            if (last && !mst && clock_phase_sel) begin
                slh_cnt <= 4'h1; // R12
                slh_run <= 1'b1;
            end else if (slh_fire || !s_act) begin
                slh_cnt <= '0;
                slh_run <= 1'b0;
            end else if (slh_run) begin
                slh_cnt <= slh_cnt + 1'b1;
            end
        end
    end

    // pin drivers; enables are low while driving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out   <= 1'b0;
            sck_oe_n  <= 1'b1;
            mosi_out  <= 1'b0;
            mosi_oe_n <= 1'b1;
        end else begin
            sck_oe_n  <= ~(en & mst); // R02
            mosi_oe_n <= ~(en & mst);
            sck_out   <= clock_polarity_sel ^ (m_edge ? ~phase : phase); // R05
            if (ms_start && !clock_phase_sel) begin
                mosi_out <= tx_buf[7];
            end else if (shft && mst) begin
                mosi_out <= sh[7];
            end
        end
    end

    // slave output reacts one cycle after each event, well inside four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_out  <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= ~s_act; // R08 R09
            if (ss_fall) begin
                miso_out <= sl_load ? tx_buf[7] : sh[7]; // R08
            end else if (shft && !mst) begin
                miso_out <= sh[7]; // R11
            end else if (slh_fire) begin
                miso_out <= sh[7]; // R12
            end
        end
    end

    scd_fifo #(
        .WIDTH (BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk     (pclk),
        .rst_n   (presetn),
        .s_valid (last),
        .s_ready (rx_ready),
        .s_data  (rx_byte),
        .m_valid (rx_valid),
        .m_ready (rd_pop),
        .m_data  (rx_head)
    );

    // helper: cycles since the serial clock pin last moved
    logic [8:0] gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= '0;
        end else if (!busy) begin
            // idle parks at zero: the start cycle fills the first half period
            gap <= 9'h000;
        end else if ($changed(sck_out)) begin
            gap <= 9'h001;
        end else if (gap != 9'h1ff) begin
            gap <= gap + 1'b1;
        end
    end

    sequence seq_ss_fall;
        $fell(slave_select_n) && en && !mst;
    endsequence
    sequence seq_ss_rise;
        $rose(slave_select_n) && en && !mst;
    endsequence

    chk_sck_half_period: assert property (@(posedge pclk) disable iff (!presetn) // R01
        busy && $past(busy) && $changed(sck_out) && $stable(clock_polarity_sel)
            && gap > 9'h001 |-> gap == {1'b0, sck_divider_value} + 9'h001)
        else $error("serial clock half period wrong");
    chk_div_master_only: assert property (@(posedge pclk) disable iff (!presetn) // R02
        !(en && mst) |=> sck_oe_n && !busy)
        else $error("serial clock driven outside master role");
    chk_write_starts: assert property (@(posedge pclk) disable iff (!presetn) // R03
        data_wr && tx_buffer_empty && en && mst && !busy && rx_ready && $stable(mst)
            |-> ##[1:2] busy)
        else $error("data write did not start a master transfer");
    chk_read_rx_data: assert property (@(posedge pclk) disable iff (!presetn) // R04
        rd && hit_data |-> prdata == {24'h0, $past(rx_head)})
        else $error("data read did not return receive buffer");
    chk_idle_polarity: assert property (@(posedge pclk) disable iff (!presetn) // R05
        !busy && !$past(busy) && $stable(clock_polarity_sel)
            |-> sck_out == clock_polarity_sel)
        else $error("idle serial clock level ignores polarity");
    chk_select_drive: assert property (@(posedge pclk) disable iff (!presetn) // R08
        seq_ss_fall |-> ##[1:4] !miso_oe_n)
        else $error("slave output not driven after select");
    chk_select_release: assert property (@(posedge pclk) disable iff (!presetn) // R09
        seq_ss_rise |-> ##[1:4] miso_oe_n)
        else $error("slave output not released after select");
    chk_shift_update: assert property (@(posedge pclk) disable iff (!presetn) // R11
        shft && !mst && !ss_fall |=> miso_out == $past(sh[7]))
        else $error("slave output not updated after shift edge");
    chk_last_change: assert property (@(posedge pclk) disable iff (!presetn) // R12
        last && !mst && clock_phase_sel ##1 s_act [*6] |-> ##[0:1] miso_out == sh[7])
        else $error("slave output not changed after last edge");
    chk_collision_flag: assert property (@(posedge pclk) disable iff (!presetn) // R13
        data_wr && !tx_buffer_empty |=> write_collision_flag && $stable(tx_buf))
        else $error("colliding write not flagged or not dropped");
    chk_eight_samples: assert property (@(posedge pclk) disable iff (!presetn) // R14
        state == SCD_FIN |-> edge_cnt == LAST_EDGE + 5'h01 && bit_cnt == '0)
        else $error("master transfer length wrong");
endmodule : scd_spi

// file: logic/scd_pkg.sv
// shared constants for the serial clock rate and data port block
// Summary of operation
// R01 - master serial clock runs at core clock over two times divider plus one
// R02 - any divider 0 to 255 is accepted; divider used only as master
// R03 - data register write fills transmit buffer; as master it starts a transfer
// R04 - data register read returns the receive buffer, never the transmit buffer
// R05 - polarity select 1 inverts the serial clock waveform
// R06 - external master waits two core clocks from select low to first edge
// R07 - external master waits two core clocks from last edge to select high
// R08 - as slave, serial output valid within four core clocks of select low
// R09 - as slave, serial output released within four core clocks of select high
// R10 - external master holds data two core clocks around each sample edge
// R11 - as slave, serial output updates within four core clocks of shift edge
// R12 - as slave with phase 1, output changes six to eight clocks after last edge
// R13 - write while transmit buffer full is dropped and sets sticky collision flag
// R14 - every transfer shifts eight bits then moves the byte to receive buffer; a slave byte ending with the fifo full is dropped and sets overrun
package scd_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_SEZ_MAX_NS  = 16;
    localparam int T_SDZ_MAX_NS  = 16;
    localparam int T_SOH_MAX_NS  = 16;
    localparam int T_SLH_MIN_NS  = 24;
    localparam int T_SLH_MAX_NS  = 32;
    localparam int SEZ_CYC       = T_SEZ_MAX_NS / CLK_PERIOD_NS;
    localparam int SDZ_CYC       = T_SDZ_MAX_NS / CLK_PERIOD_NS;
    localparam int SOH_CYC       = T_SOH_MAX_NS / CLK_PERIOD_NS;
    localparam int SLH_MIN_CYC   = (T_SLH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLH_MAX_CYC   = T_SLH_MAX_NS / CLK_PERIOD_NS;
    localparam int SLH_CYC       = (SLH_MIN_CYC + SLH_MAX_CYC) / 2;
    localparam logic [3:0] SLH_FIRE = 4'(SLH_CYC - 1);

    localparam int BITS           = 8;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [4:0] LAST_EDGE = 5'h0f;
    localparam int MIN_ADDR_W     = 10;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CTRL   = 8'ha0;
    localparam logic [7:0] IDX_STATUS = 8'ha1;
    localparam logic [7:0] IDX_DIV    = 8'ha2;
    localparam logic [7:0] IDX_DATA   = 8'ha3;

    localparam logic [7:0] DIV_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // control fields
    localparam int CTRL_EN   = 0;
    localparam int CTRL_MST  = 1;
    localparam int CTRL_CPOL = 2;
    localparam int CTRL_CPHA = 3;
    // status fields
    localparam int ST_TXE  = 0;
    localparam int ST_WRITE_COLLISION_FLAG = 1;
    localparam int ST_DONE = 2;
    localparam int ST_RXV  = 3;
    localparam int ST_OVR  = 4;
    localparam int ST_BUSY = 5;

    typedef enum logic [1:0] {
        SCD_IDLE = 2'b00,
        SCD_RUN  = 2'b01,
        SCD_FIN  = 2'b11
    } scd_state_e;

    function automatic logic scd_hit(input logic [11:0] addr, input logic [7:0] idx);
        scd_hit = (addr == {2'h0, idx, 2'h0});
    endfunction : scd_hit
endpackage : scd_pkg

// file: logic/scd_fifo.sv
// receive fifo with registered read data
`timescale 1ns/1ns
module scd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             s_valid,
    output logic                  s_ready,
    input  wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic                  m_valid,
    input  wire logic             m_ready,
    output logic [WIDTH-1:0]      m_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("scd_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    logic [AW-1:0]    next_rd_ptr;

    assign s_ready     = (count != (AW+1)'(DEPTH));
    assign m_valid     = (count != '0);
    assign push        = s_valid & s_ready;
    assign pop         = m_valid & m_ready;
    assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= s_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            rd_ptr <= next_rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // bypass covers a write landing on the head slot in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_data <= '0;
        end else if (push && wr_ptr == next_rd_ptr) begin
            m_data <= s_data;
        end else if (count != (AW+1)'(pop)) begin
            // an empty fifo keeps its last head, so unwritten slots never show
            m_data <= mem[next_rd_ptr];
        end
    end

    chk_fifo_no_overfill: assert property (@(posedge clk) disable iff (!rst_n) // R14
        !s_ready |=> (count == (AW+1)'(DEPTH)) || $past(m_ready))
        else $error("fifo count wrong while full");
endmodule : scd_fifo

// file: verification/scd_partner.sv
// external serial slave model facing the block in master role
`timescale 1ns/1ns
module scd_partner #(
    parameter logic [7:0] TX_BYTE = 8'h3c
) (
    // serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // byte seen on the data line
    output logic [7:0]      got
);
    logic [7:0] tx;
    // polarity 0, phase 0 only: the bench runs one master transfer
    initial begin
        miso = 1'b0;
        got  = 8'h00;
        tx   = 8'h00;
    end
    always @(negedge sel_n) begin
        tx   = TX_BYTE;
        miso = TX_BYTE[7];
    end
    // released line shows the inverse so a stale sample cannot pass
    always @(posedge sel_n) miso = ~miso;
    always @(posedge sck) got = {got[6:0], mosi};
    always @(negedge sck) begin
        if (!sel_n) begin
            tx   = tx << 1;
            miso = tx[7];
        end
    end
endmodule : scd_partner

// file: verification/testbench.sv
// self-checking bench for the serial clock rate and data port
`timescale 1ns/1ns
module testbench;
    import scd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sck_in, sck_out, sck_oe_n, mosi_in, mosi_out, mosi_oe_n;
    logic        miso_in, miso_out, miso_oe_n, slave_select_n, part_sel_n;
    logic [7:0]  got;
    int          n_mismatch, checks, t;
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_ST   = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [11:0] A_DIV  = {2'h0, IDX_DIV, 2'h0};
    localparam logic [11:0] A_DATA = {2'h0, IDX_DATA, 2'h0};

    scd_spi #(.ADDR_W(12), .FIFO_DEPTH(8)) scd_spi_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .sck_in, .sck_out, .sck_oe_n, .mosi_in, .mosi_out,
        .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n, .slave_select_n);
    scd_partner scd_partner_i (.sck(sck_out), .mosi(mosi_out), .sel_n(part_sel_n),
        .miso(miso_in), .got(got));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic summarize;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer, entered right after a rising edge
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : rw

    // cycles until sck_out next changes
    task automatic toggle_wait;
        logic p;
        p = sck_out;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (sck_out === p && t < 100);
    endtask : toggle_wait

    task automatic t_regs;
        rw(0, A_DIV, 0);
        chk("divider reset", rd, 32'h0000_0000);
        rw(0, A_DATA, 0);
        chk("data reset", rd, 32'h0000_0000);
        rw(0, 12'h3f0, 0);
        chk("unmapped err", {31'h0, err}, 32'h0000_0001);
        rw(1, A_DIV, 32'h0000_00ff);
        rw(0, A_DIV, 0);
        chk("divider max", rd, 32'h0000_00ff);
        rw(1, A_DIV, 32'h0000_0002);
        $display("test regs done");
    endtask : t_regs

    task automatic t_master;
        int i;
        rw(1, A_CTRL, 32'h0000_0003);
        part_sel_n <= 1'b0;
        rw(1, A_DATA, 32'h0000_00a5);
        toggle_wait();
        toggle_wait();
        chk("half period", t, 3);
        chk("pins driven", {30'h0, sck_oe_n, mosi_oe_n}, 32'h0000_0000);
        for (i = 0; i < 40; i++) begin
            rw(0, A_ST, 0);
            if (rd[ST_DONE] === 1'b1)
                break;
        end
        if (i >= 40) begin
            n_mismatch++;
            summarize();
        end
        chk("byte sent", {24'h0, got}, 32'h0000_00a5);
        rw(0, A_DATA, 0);
        chk("byte received", rd, 32'h0000_003c);
        part_sel_n <= 1'b1;
        $display("test master done");
    endtask : t_master

    task automatic t_pol;
        rw(1, A_CTRL, 32'h0000_0007);
        repeat (3) @(posedge pclk);
        chk("idle sck pol1", {31'h0, sck_out}, 32'h0000_0001);
        rw(1, A_CTRL, 32'h0000_0003);
        repeat (3) @(posedge pclk);
        chk("idle sck pol0", {31'h0, sck_out}, 32'h0000_0000);
        $display("test polarity done");
    endtask : t_pol

    // disabled block keeps the buffer full, so the second write collides
    task automatic t_write_collision_flag;
        rw(1, A_CTRL, 32'h0000_0000);
        rw(1, A_DATA, 32'h0000_0081);
        chk("pins released", {30'h0, sck_oe_n, mosi_oe_n}, 32'h0000_0003);
        rw(1, A_DATA, 32'h0000_007e);
        rw(0, A_ST, 0);
        chk("collision set", rd[1:0], 2'b10);
        rw(1, A_ST, 32'h0000_0002);
        rw(0, A_ST, 0);
        chk("collision clear", rd[1:0], 2'b00);
        $display("test collision done");
    endtask : t_write_collision_flag

    // bench acts as external master; loaded byte is 8'h81
    task automatic t_slave;
        rw(1, A_CTRL, 32'h0000_0001);
        slave_select_n <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("miso enabled", {31'h0, miso_oe_n}, 32'h0000_0000);
        chk("miso bit7", {31'h0, miso_out}, 32'h0000_0001);
        sck_in <= 1'b1;
        repeat (5) @(posedge pclk);
        sck_in <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("miso bit6", {31'h0, miso_out}, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        slave_select_n <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("miso released", {31'h0, miso_oe_n}, 32'h0000_0001);
        $display("test slave done");
    endtask : t_slave

    // bench as external master with phase 1: sends 8'h5a while the block sends 8'hc3
    task automatic t_slave_ph1;
        int i;
        logic [7:0] d;
        d = 8'h5a;
        rw(1, A_CTRL, 32'h0000_0009);
        rw(1, A_DATA, 32'h0000_00c3);
        slave_select_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (i = 0; i < 16; i++) begin
            sck_in <= ~sck_in;
            if (i % 2 == 0) begin
                mosi_in <= d[7];
                d = d << 1;
            end
            repeat (5) @(posedge pclk);
        end
        chk("miso held after last", {31'h0, miso_out}, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("miso after last", {31'h0, miso_out}, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        slave_select_n <= 1'b1;
        rw(0, A_DATA, 0);
        chk("slave byte received", rd, 32'h0000_005a);
        $display("test slave phase 1 done");
    endtask : t_slave_ph1

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sck_in, mosi_in} = '0;
        paddr = '0;
        pwdata = '0;
        slave_select_n = 1'b1;
        part_sel_n = 1'b1;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_master();
        t_pol();
        t_write_collision_flag();
        t_slave();
        t_slave_ph1();
        summarize();
    end
endmodule : testbench
